//--- verilog/twdt_top.sv
// What this block does
// [RULE_01] enabled 32-bit counter decrements, zero is time-out
// [RULE_02] starting the count also enables the interrupt
// [RULE_03] after first time-out reload and keep counting
// [RULE_04] second time-out while pending asserts system reset
// [RULE_05] cleared before second time-out reloads counter
// [RULE_06] reload write loads counter immediately
// [RULE_07] reload write leaves pending interrupt set
// [RULE_08] software clears interrupt only via clear register
// [RULE_09] re-enabling interrupt preloads counter from reload value
// [RULE_10] interrupt and reset generation each software switchable
// [RULE_11] setting enable starts watchdog and locks control
// [RULE_12] any lock register write other than the unlock key locks all other registers
// [RULE_13] unlock key write unlocks the registers
// [RULE_14] software order: reload, reset enable, enable
// [RULE_15] software enables clock gate before access
// [RULE_16] clear register write clears interrupt and reloads
// [RULE_17] masked status is raw AND enable
// [RULE_18] control writes ignored after enable until reset
// [RULE_19] lock read returns one locked, zero unlocked
// [RULE_20] raw status sticky until clear or reset
// [RULE_21] locked ignores writes except lock register
`timescale 1ns/1ps
`default_nettype none
module twdt_top
    import twdt_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic clock_enable_i,
    input wire logic [11:0] address_i,
    input wire logic [31:0] write_data_i,
    input wire logic write_strobe_i,
    input wire logic read_strobe_i,
    output logic [31:0] read_data_o,
    output logic irq_o,
    output logic system_reset_o
);
    typedef struct packed {
        logic [31:0] wd_reload_value;
        logic [31:0] count;
        logic irq_and_count_enable;
        logic reset_output_enable;
        logic wd_raw_irq_status;
        logic wd_write_lock;
        logic system_reset;
        logic irq;
        logic [31:0] read_data;
    } twdt_state_t;

    twdt_state_t state;
    twdt_state_t next_state;

    // address decode used by the write path; the read path decodes with its own case
    function automatic logic twdt_hit(input logic [11:0] addr, input logic [11:0] offset);
        twdt_hit = (addr == offset);
    endfunction : twdt_hit

    logic wr_reload;
    logic wr_control;
    logic wr_clear;
    logic wr_lock;
    logic timeout;

    // writes other than the lock itself are dropped while locked
    assign wr_lock = write_strobe_i && twdt_hit(address_i, TWDT_OFF_WRITE_LOCK);
    assign wr_reload = write_strobe_i && !state.wd_write_lock
        && twdt_hit(address_i, TWDT_OFF_RELOAD); // [RULE_21]
    assign wr_control = write_strobe_i && !state.wd_write_lock && !state.irq_and_count_enable
        && twdt_hit(address_i, TWDT_OFF_CONTROL); // [RULE_18] [RULE_21]
    assign wr_clear = write_strobe_i && !state.wd_write_lock
        && twdt_hit(address_i, TWDT_OFF_IRQ_CLEAR); // [RULE_21]
    // a zero count while running is a time-out; a zero reload fires at once
    assign timeout = state.irq_and_count_enable && (state.count == TWDT_ZERO); // [RULE_01]

    // next-state logic
    always_comb begin
        next_state = state;
        // counting: decrement, or reload on time-out
        if (state.irq_and_count_enable) begin
            if (timeout) begin
                next_state.count = state.wd_reload_value; // [RULE_03]
            end else begin
                next_state.count = state.count - TWDT_ONE; // [RULE_01]
            end
        end
        // second time-out with the flag still pending pulls system reset
        if (timeout && state.wd_raw_irq_status && state.reset_output_enable) begin
            next_state.system_reset = 1'b1; // [RULE_04] [RULE_10]
        end
        // clear reloads the counter and drops the flag
        if (wr_clear) begin
            next_state.wd_raw_irq_status = 1'b0; // [RULE_16] [RULE_05] [RULE_08]
            next_state.count = state.wd_reload_value; // [RULE_16] [RULE_05]
        end
        // a time-out in the clear cycle wins so the event is not lost
        if (timeout) begin
            next_state.wd_raw_irq_status = 1'b1; // [RULE_20]
        end
        // reload write restarts the count but keeps the flag
        if (wr_reload) begin
            next_state.wd_reload_value = write_data_i;
            next_state.count = write_data_i; // [RULE_06] [RULE_07]
        end
        // control write: enabling preloads from the reload value
        if (wr_control) begin
            next_state.reset_output_enable = write_data_i[TWDT_BIT_RESET_EN]; // [RULE_10]
            next_state.irq_and_count_enable = write_data_i[TWDT_BIT_IRQ_EN]; // [RULE_02] [RULE_11]
            if (write_data_i[TWDT_BIT_IRQ_EN]) begin
                next_state.count = wr_reload ? write_data_i : state.wd_reload_value; // [RULE_09]
            end
        end
        // lock register: key unlocks, anything else locks
        if (wr_lock) begin
            next_state.wd_write_lock = (write_data_i != TWDT_UNLOCK_KEY); // [RULE_12] [RULE_13]
        end
        // masked line follows raw and enable, registered for a clean output
        next_state.irq = next_state.wd_raw_irq_status
            && next_state.irq_and_count_enable; // [RULE_17] [RULE_02]
        // read data stand only in the cycle after the strobe
        next_state.read_data = TWDT_ZERO;
        if (read_strobe_i) begin
            case (address_i)
                TWDT_OFF_RELOAD: begin
                    next_state.read_data = state.wd_reload_value;
                end
                TWDT_OFF_VALUE: begin
                    next_state.read_data = state.count;
                end
                TWDT_OFF_CONTROL: begin
                    next_state.read_data[TWDT_BIT_IRQ_EN] = state.irq_and_count_enable;
                    next_state.read_data[TWDT_BIT_RESET_EN] = state.reset_output_enable;
                end
                TWDT_OFF_RAW_STATUS: begin
                    next_state.read_data[0] = state.wd_raw_irq_status;
                end
                TWDT_OFF_MASKED_STATUS: begin
                    next_state.read_data[0] = state.wd_raw_irq_status
                        && state.irq_and_count_enable; // [RULE_17]
                end
                TWDT_OFF_WRITE_LOCK: begin
                    next_state.read_data = state.wd_write_lock ? TWDT_LOCK_READ_LOCKED
                        : TWDT_LOCK_READ_UNLOCKED; // [RULE_19]
                end
                default: begin
                    next_state.read_data = TWDT_ZERO;
                end
            endcase
        end
    end

    // state register; reset still acts while gated, clock enable freezes everything else
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state.wd_reload_value <= TWDT_RELOAD_RESET;
            state.count <= TWDT_RELOAD_RESET;
            state.irq_and_count_enable <= 1'b0;
            state.reset_output_enable <= 1'b0;
            state.wd_raw_irq_status <= 1'b0;
            state.wd_write_lock <= 1'b0;
            state.system_reset <= 1'b0;
            state.irq <= 1'b0;
            state.read_data <= TWDT_ZERO;
        end else if (clock_enable_i) begin
            state <= next_state;
        end
    end

    assign read_data_o = state.read_data;
    assign irq_o = state.irq;
    assign system_reset_o = state.system_reset;
endmodule : twdt_top
`default_nettype wire

//--- verilog/twdt_pkg.sv
package twdt_pkg;
    // register byte offsets
    localparam logic [11:0] TWDT_OFF_RELOAD = 12'h000;
    localparam logic [11:0] TWDT_OFF_VALUE = 12'h004;
    localparam logic [11:0] TWDT_OFF_CONTROL = 12'h008;
    localparam logic [11:0] TWDT_OFF_IRQ_CLEAR = 12'h00c;
    localparam logic [11:0] TWDT_OFF_RAW_STATUS = 12'h010;
    localparam logic [11:0] TWDT_OFF_MASKED_STATUS = 12'h014;
    localparam logic [11:0] TWDT_OFF_WRITE_LOCK = 12'hc00;
    // control field positions
    localparam int TWDT_BIT_IRQ_EN = 0;
    localparam int TWDT_BIT_RESET_EN = 1;
    // reset values and keys
    localparam logic [31:0] TWDT_RELOAD_RESET = 32'hffffffff;
    localparam logic [31:0] TWDT_UNLOCK_KEY = 32'h1acce551;
    localparam logic [31:0] TWDT_LOCK_READ_LOCKED = 32'h00000001;
    localparam logic [31:0] TWDT_LOCK_READ_UNLOCKED = 32'h00000000;
    localparam logic [31:0] TWDT_ZERO = 32'h00000000;
    localparam logic [31:0] TWDT_ONE = 32'h00000001;
endpackage : twdt_pkg

//--- dv/twdt_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module twdt_chk
    import twdt_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic clock_enable_i,
    input wire logic [11:0] address_i,
    input wire logic [31:0] write_data_i,
    input wire logic write_strobe_i,
    input wire logic read_strobe_i,
    input wire logic [31:0] read_data_o,
    input wire logic irq_o,
    input wire logic system_reset_o
);
    logic locked;
    logic en;
    wire logic wt = clock_enable_i && write_strobe_i;
    wire logic rt = clock_enable_i && read_strobe_i;
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    // shadow of lock and enable; enable is sticky so refused writes need no care
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            locked <= 1'h0;
            en <= 1'h0;
        end else if (wt && address_i == TWDT_OFF_WRITE_LOCK) begin
            locked <= write_data_i != TWDT_UNLOCK_KEY;
        end else if (wt && !locked && address_i == TWDT_OFF_CONTROL && write_data_i[0]) begin
            en <= 1'h1;
        end
    end
    // read port, lock status, reload, masking, reset output
    read_idle_a:
        assert property (clock_enable_i && !read_strobe_i |=> read_data_o == TWDT_ZERO)
        else $error("read data not idle");
    lock_read_a:
        assert property (rt && address_i == TWDT_OFF_WRITE_LOCK
            |=> read_data_o == {31'h0, $past(locked)}) else $error("lock status wrong");
    load_now_a:
        assert property (wt && !locked && address_i == TWDT_OFF_RELOAD ##1 rt
            && address_i == TWDT_OFF_VALUE |=> read_data_o == $past(write_data_i, 2))
        else $error("reload not loaded");
    masked_read_a:
        assert property (rt && address_i == TWDT_OFF_MASKED_STATUS
            |=> read_data_o == {31'h0, $past(irq_o)}) else $error("masked status wrong");
    irq_gate_a:
        assert property (!en |-> !irq_o) else $error("irq while disabled");
    reset_hold_a:
        assert property (system_reset_o |=> system_reset_o) else $error("reset dropped");
    reset_cause_a:
        assert property ($rose(system_reset_o) |-> $past(irq_o)) else $error("reset no irq");
    freeze_all_a:
        assert property (!clock_enable_i |=> $stable(read_data_o) && $stable(irq_o)
            && $stable(system_reset_o)) else $error("state moved while gated");
    cover property ($rose(irq_o));
    cover property ($rose(system_reset_o));
    cover property (rt && address_i == TWDT_OFF_WRITE_LOCK && locked);
    cover property (wt && address_i == TWDT_OFF_IRQ_CLEAR && irq_o);
endmodule : twdt_chk
bind twdt_top twdt_chk u_chk (.clock_i, .reset_i, .clock_enable_i, .address_i,
    .write_data_i, .write_strobe_i, .read_strobe_i, .read_data_o, .irq_o, .system_reset_o);
`default_nettype wire

//--- dv/twdt_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module twdt_tb_top
    import twdt_pkg::*;
;
    logic clock_i = 1'h0;
    logic reset_i = 1'h1;
    logic clock_enable_i = 1'h1;
    logic [11:0] address_i = 12'h000;
    logic [31:0] write_data_i = 32'h0;
    logic write_strobe_i = 1'h0;
    logic read_strobe_i = 1'h0;
    logic [31:0] read_data_o;
    logic irq_o;
    logic system_reset_o;
    int mismatches = 0;
    int check_count = 0;
    typedef struct {logic w; logic [11:0] a; logic [31:0] d;} twdt_row_t;
    // reset values, lock, refused write while locked, unlock, immediate load
    twdt_row_t rows [13] = '{'{1'h0, TWDT_OFF_RELOAD, TWDT_RELOAD_RESET},
        '{1'h0, TWDT_OFF_VALUE, TWDT_RELOAD_RESET}, '{1'h0, TWDT_OFF_CONTROL, TWDT_ZERO},
        '{1'h0, TWDT_OFF_RAW_STATUS, TWDT_ZERO}, '{1'h0, TWDT_OFF_WRITE_LOCK, TWDT_ZERO},
        '{1'h0, 12'h418, TWDT_ZERO}, '{1'h1, TWDT_OFF_WRITE_LOCK, TWDT_ZERO},
        '{1'h0, TWDT_OFF_WRITE_LOCK, TWDT_ONE}, '{1'h1, TWDT_OFF_RELOAD, 32'h5},
        '{1'h0, TWDT_OFF_RELOAD, TWDT_RELOAD_RESET}, '{1'h1, TWDT_OFF_WRITE_LOCK, TWDT_UNLOCK_KEY},
        '{1'h1, TWDT_OFF_RELOAD, 32'h14}, '{1'h0, TWDT_OFF_VALUE, 32'h14}};
    // 4 ns period
    always #2 clock_i = ~clock_i;
    twdt_top uut (.clock_i, .reset_i, .clock_enable_i, .address_i, .write_data_i,
        .write_strobe_i, .read_strobe_i, .read_data_o, .irq_o, .system_reset_o);
    // shared compare, bus cycles and waits; all start just after an edge
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // idle wait drops both strobes; bus tasks leave theirs up so back-to-back calls never
    // assign a strobe twice in one time step
    task automatic tick(input int n);
        write_strobe_i <= 1'h0;
        read_strobe_i <= 1'h0;
        repeat (n) @(posedge clock_i);
        #1;
    endtask : tick
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        address_i <= a;
        write_data_i <= d;
        write_strobe_i <= 1'h1;
        read_strobe_i <= 1'h0;
        @(posedge clock_i);
        #1;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        address_i <= a;
        write_strobe_i <= 1'h0;
        read_strobe_i <= 1'h1;
        @(posedge clock_i);
        #1;
        check(read_data_o, e);
    endtask : rd
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    // main sequence: table, two time-outs, gating, reset in mid-run
    initial begin
        tick(12);
        reset_i <= 1'h0;
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            else rd(rows[i].a, rows[i].d);
        end
        $display("table done");
        wr(TWDT_OFF_CONTROL, 32'h3);
        tick(15);
        check(irq_o, 1'h0);
        tick(10);
        check(irq_o, 1'h1);
        wr(TWDT_OFF_RELOAD, 32'h28);
        rd(TWDT_OFF_VALUE, 32'h28);
        rd(TWDT_OFF_RAW_STATUS, TWDT_ONE);
        rd(TWDT_OFF_MASKED_STATUS, TWDT_ONE);
        wr(TWDT_OFF_CONTROL, TWDT_ZERO);
        rd(TWDT_OFF_CONTROL, 32'h3);
        wr(TWDT_OFF_IRQ_CLEAR, TWDT_ZERO);
        rd(TWDT_OFF_RAW_STATUS, TWDT_ZERO);
        tick(37);
        check(irq_o, 1'h0);
        clock_enable_i <= 1'h0;
        tick(10);
        clock_enable_i <= 1'h1;
        tick(50);
        check(system_reset_o, 1'h1);
        $display("time-out done");
        reset_i <= 1'h1;
        tick(2);
        reset_i <= 1'h0;
        check(system_reset_o, 1'h0);
        rd(TWDT_OFF_CONTROL, TWDT_ZERO);
        wr(TWDT_OFF_RELOAD, 32'ha);
        wr(TWDT_OFF_CONTROL, TWDT_ONE);
        rd(TWDT_OFF_VALUE, 32'ha);
        tick(30);
        check({irq_o, system_reset_o}, 32'h2);
        $display("reset done");
        wrap_up();
    end
    // whole run needs about 190 cycles, so 1000 cycles means a hang
    initial begin
        #4000;
        mismatches++;
        wrap_up();
    end
endmodule : twdt_tb_top
`default_nettype wire
